// *** mqu_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module mqu_checker
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire logic req_write_in,
   input wire logic [31:0] req_addr_in,
   input wire logic [31:0] req_wdata_in,
   input wire logic resp_valid_out,
   input wire logic resp_retry_out,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic lreg_wr_in,
   input wire logic pci_inta_n_out,
   input wire logic local_int_out,
   input wire logic local_fatal_error_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);
   // request held to ack
   mem_hold_a:
      assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
      else $error("request dropped");
   // retry while write pending
   retry_pend_a:
      assert property (req_valid_in && req_ready_out && mem_req_out && mem_we_out
         && !resp_valid_out |=> resp_valid_out && resp_retry_out)
      else $error("no retry");
   // full only after completion
   fatal_rise_a:
      assert property ($rose(local_fatal_error_out) |-> $past(mem_ack_in) || $past(mem_ack_in, 2))
      else $error("stray fatal");
   // interrupt needs a cause
   inta_fall_a:
      assert property ($fell(pci_inta_n_out) |-> $past(lreg_wr_in)
         || $past(req_valid_in && req_ready_out && req_write_in))
      else $error("stray irq");
   // clear needs a cause
   inta_rise_a:
      assert property ($rose(pci_inta_n_out) |-> $past(lreg_wr_in)
         || $past(req_valid_in && req_ready_out) || $past(req_valid_in && req_ready_out, 2))
      else $error("stray clear");
   // local irq needs a cause
   lint_rise_a:
      assert property ($rose(local_int_out) |-> $past(lreg_wr_in) || $past(mem_ack_in)
         || $past(mem_ack_in, 2))
      else $error("stray local irq");
   // window answers next cycle
   resp_next_a:
      assert property (req_valid_in && req_ready_out && !resp_valid_out
         && req_addr_in[31:8] == 24'h000000 |=> resp_valid_out)
      else $error("late answer");
   // write data passes through
   wdata_pass_a:
      assert property ($rose(mem_req_out) && mem_we_out |-> mem_wdata_out == $past(req_wdata_in))
      else $error("bad write data");
endmodule
`default_nettype wire

// *** mqu_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mqu_mem_model
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] lat_in,
   output logic ack_out,
   output logic [31:0] rdata_out,
   output logic [31:0] wr_addr_out,
   output logic [31:0] wr_data_out
);
   logic [3:0] cnt_q;
   // ack after lat_in waits; data toggles between acks
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ack_out <= 1'b0;
         cnt_q <= 4'h0;
         rdata_out <= 32'h0000_0000;
         wr_addr_out <= 32'h0000_0000;
         wr_data_out <= 32'h0000_0000;
      end
      else
      begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         if (req_in && !ack_out && cnt_q == lat_in)
         begin
            ack_out <= 1'b1;
            cnt_q <= 4'h0;
            rdata_out <= addr_in ^ 32'hA5A5_0000;
            if (we_in)
            begin
               wr_addr_out <= addr_in;
               wr_data_out <= wdata_in;
            end
         end
         else if (req_in && !ack_out)
            cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule
`default_nettype wire

// *** mqu_message_queue_unit.sv ***
// Behaviour
// - empty outbound post read returns all ones
// - non-empty read returns tail entry, advances tail
// - pci interrupt while outbound post non-empty
// - interrupt and status clear when drained
// - mask register suppresses outbound post interrupt
// - outbound post tail prefetched when needed
// - inbound free tail prefetched the same way
// - outbound port write stores at free head
// - free head meeting tail flags fatal error
// - retry all accesses while port write pending
// - retry everything until init done set
// - decode on: low window reaches registers
// - decode on: above window maps to space1
// - inbound post raises local interrupt only
// - hardware pointers wrap at queue size
// - five-bit size field, four equal queues
// - empty when disabled or pointers equal
`timescale 1ns/1ps
`default_nettype none
module mqu_message_queue_unit
#(
   parameter int RESP_DEPTH = 2
)
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic req_write_in,
   input wire logic [31:0] req_addr_in,
   input wire logic [31:0] req_wdata_in,
   output logic resp_valid_out,
   input wire logic resp_ready_in,
   output logic [31:0] resp_data_out,
   output logic resp_retry_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in,
   input wire logic lreg_wr_in,
   input wire logic [7:0] lreg_addr_in,
   input wire logic [31:0] lreg_wdata_in,
   output logic [31:0] lreg_rdata_out,
   output logic pci_inta_n_out,
   output logic local_int_out,
   output logic local_fatal_error_out
);
   import mqu_pkg::*;

   typedef struct packed {
      mqu_state_t st;
      logic q_en;
      logic [4:0] q_size;
      logic [11:0] q_base;
      logic decode_en;
      logic ip_mask;
      logic ofl_full;
      logic op_mask;
      logic init_done;
      logic [31:0] class_code;
      logic [27:0] s1_remap;
      logic [1:0] pf_valid;
      logic [1:0][31:0] pf_data;
      logic [1:0] job_q;
      logic mem_req;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic [31:0] s1_data;
      logic [31:0] lreg_rdata;
   } mqu_state_struct_t;

   mqu_state_struct_t s_q;
   mqu_state_struct_t s_d;

   logic [NUM_PTR-1:0][PTR_W-1:0] ptr;
   logic [NUM_PTR-1:0] ptr_inc;
   logic [NUM_PTR-1:0] ptr_load;
   logic [3:0] q_empty;
   logic [1:0] pf_need;
   logic [PTR_W-1:0] size_b;
   logic buf_ready;
   logic push;
   logic push_retry;
   logic [31:0] push_data;
   logic take;
   logic in_win;
   logic is_port;
   logic [1:0] port_q;
   logic slot;

   assign size_b = mqu_size_bytes(s_q.q_size);

   // io processor loads any pointer; hardware steps its own
   for (genvar i = 0; i < NUM_PTR; i++)
   begin : g_ptr
      assign ptr_load[i] = lreg_wr_in &&
         (lreg_addr_in == OFF_PTR0 + OFF_PTR_STEP * 8'(i));
      mqu_ptr u_ptr (
         .clk_in(clk_in),
         .arst_n_in(arst_n_in),
         .load_in(ptr_load[i]),
         .load_val_in(lreg_wdata_in[PTR_W-1:0]),
         .inc_in(ptr_inc[i]),
         .size_in(size_b),
         .ptr_out(ptr[i])
      );
   end

   // empty flags per queue, forced when the queues are disabled
   for (genvar k = 0; k < 4; k++)
   begin : g_empty
      assign q_empty[k] = !s_q.q_en || (ptr[2*k] == ptr[2*k+1]);
   end

   // a slot needs a fetch whenever its queue holds data and the slot is stale;
   // covers tail-advance and head-from-empty
   assign pf_need[0] = !q_empty[Q_IN_FREE] && !s_q.pf_valid[0];
   assign pf_need[1] = !q_empty[Q_OUT_POST] && !s_q.pf_valid[1];

   // request decode inside the first memory base
   assign in_win = (req_addr_in <= REG_WINDOW_TOP);
   assign is_port = in_win && (req_addr_in[7:0] == OFF_IQP || req_addr_in[7:0] == OFF_OQP);
   assign port_q = (req_addr_in[7:0] == OFF_IQP) ?
      (req_write_in ? Q_IN_POST : Q_IN_FREE) :
      (req_write_in ? Q_OUT_FREE : Q_OUT_POST);
   assign slot = port_q[1];

   // space1 holds off requests to keep answers in order
   always_comb
   begin
      case (s_q.st)
         MQU_IDLE: req_ready_out = buf_ready && (pf_need == 2'b00);
         MQU_POST_WR: req_ready_out = buf_ready;
         MQU_FETCH: req_ready_out = buf_ready;
         default: req_ready_out = 1'b0;
      endcase
   end
   assign take = req_valid_in && req_ready_out;

   // register view for local port and low window
   function automatic logic [31:0] reg_read(input logic [7:0] off);
      logic [31:0] r;
      r = RST_WORD;
      case (off)
         OFF_QCFG:
         begin
            r[QCFG_EN_BIT] = s_q.q_en;
            r[QCFG_SIZE_LSB +: 5] = s_q.q_size;
         end
         OFF_QUEUE_BASE_ADDRESS: r[QUEUE_BASE_ADDRESS_LSB +: 12] = s_q.q_base;
         OFF_QSR:
         begin
            r[QSR_DECODE_BIT] = s_q.decode_en;
            r[QSR_IPMASK_BIT] = s_q.ip_mask;
            r[QSR_IPIRQ_BIT] = !q_empty[Q_IN_POST];
            r[QSR_OFULL_BIT] = s_q.ofl_full;
         end
         OFF_OPIS: r[OPIS_IRQ_BIT] = !q_empty[Q_OUT_POST];
         OFF_OPIM: r[OPIM_MASK_BIT] = s_q.op_mask;
         OFF_LOCAL_MISC_CONTROL: r[LOCAL_MISC_CONTROL_INIT_BIT] = s_q.init_done;
         OFF_CLASS: r = s_q.class_code;
         OFF_S1RB: r[S1RB_LSB +: 28] = s_q.s1_remap;
         default:
         begin
            for (int j = 0; j < NUM_PTR; j++)
            begin
               if (off == OFF_PTR0 + OFF_PTR_STEP * 8'(j))
               begin
                  r[PTR_W-1:0] = ptr[j];
               end
            end
         end
      endcase
      return r;
   endfunction

   // main sequencer
   always_comb
   begin
      s_d = s_q;
      ptr_inc = '0;
      push = 1'b0;
      push_retry = 1'b0;
      push_data = RST_WORD;
      s_d.lreg_rdata = reg_read(lreg_addr_in);

      // local register writes
      if (lreg_wr_in)
      begin
         case (lreg_addr_in)
            OFF_QCFG:
            begin
               s_d.q_en = lreg_wdata_in[QCFG_EN_BIT];
               s_d.q_size = lreg_wdata_in[QCFG_SIZE_LSB +: 5];
            end
            OFF_QUEUE_BASE_ADDRESS: s_d.q_base = lreg_wdata_in[QUEUE_BASE_ADDRESS_LSB +: 12];
            OFF_QSR:
            begin
               s_d.decode_en = lreg_wdata_in[QSR_DECODE_BIT];
               s_d.ip_mask = lreg_wdata_in[QSR_IPMASK_BIT];
               if (lreg_wdata_in[QSR_OFULL_BIT])
               begin
                  s_d.ofl_full = 1'b0; // write one to clear
               end
            end
            OFF_OPIM: s_d.op_mask = lreg_wdata_in[OPIM_MASK_BIT];
            OFF_LOCAL_MISC_CONTROL: s_d.init_done = lreg_wdata_in[LOCAL_MISC_CONTROL_INIT_BIT];
            OFF_CLASS: s_d.class_code = lreg_wdata_in;
            OFF_S1RB: s_d.s1_remap = lreg_wdata_in[S1RB_LSB +: 28];
            default: ;
         endcase
      end
      // a tail reload makes its prefetch stale
      if (ptr_load[2*Q_IN_FREE+1])
      begin
         s_d.pf_valid[0] = 1'b0;
      end
      if (ptr_load[2*Q_OUT_POST+1])
      begin
         s_d.pf_valid[1] = 1'b0;
      end

      case (s_q.st)
         MQU_IDLE:
         begin
            if (take)
            begin
               push = 1'b1;
               if (!s_q.init_done)
               begin
                  push_retry = 1'b1;
               end
               else if (is_port && req_write_in)
               begin
                  // posted write: answered at once; later accesses retry until memory and head done
                  s_d.job_q = port_q;
                  s_d.mem_req = 1'b1;
                  s_d.mem_we = 1'b1;
                  s_d.mem_wdata = req_wdata_in;
                  s_d.mem_addr = mqu_qaddr(s_q.q_base, port_q, size_b,
                                           ptr[2*port_q]);
                  s_d.st = MQU_POST_WR;
               end
               else if (is_port)
               begin
                  if (q_empty[port_q])
                  begin
                     push_data = EMPTY_WORD;
                  end
                  else if (s_q.pf_valid[slot])
                  begin
                     push_data = s_q.pf_data[slot];
                     ptr_inc[2*port_q+1] = 1'b1;
                     s_d.pf_valid[slot] = 1'b0;
                  end
                  else
                  begin
                     push_retry = 1'b1;
                  end
               end
               else if (in_win)
               begin
                  // host writes only the outbound post mask
                  if (req_write_in && req_addr_in[7:0] == OFF_OPIM)
                  begin
                     if (lreg_wr_in)
                     begin
                        push_retry = 1'b1;
                     end
                     else
                     begin
                        s_d.op_mask = req_wdata_in[OPIM_MASK_BIT];
                     end
                  end
                  else if (!req_write_in)
                  begin
                     push_data = reg_read(req_addr_in[7:0]);
                  end
               end
               else if (s_q.decode_en)
               begin
                  push = 1'b0;
                  s_d.mem_req = 1'b1;
                  s_d.mem_we = req_write_in;
                  s_d.mem_wdata = req_wdata_in;
                  s_d.mem_addr = {s_q.s1_remap, 4'h0} + req_addr_in;
                  s_d.st = MQU_SPACE1;
               end
            end
            else if (pf_need != 2'b00)
            begin
               s_d.job_q = pf_need[0] ? Q_IN_FREE : Q_OUT_POST;
               s_d.mem_req = 1'b1;
               s_d.mem_we = 1'b0;
               s_d.mem_addr = pf_need[0] ?
                  mqu_qaddr(s_q.q_base, Q_IN_FREE, size_b, ptr[2*Q_IN_FREE+1]) :
                  mqu_qaddr(s_q.q_base, Q_OUT_POST, size_b, ptr[2*Q_OUT_POST+1]);
               s_d.st = MQU_FETCH;
            end
         end
         MQU_POST_WR:
         begin
            if (take)
            begin
               push = 1'b1;
               push_retry = 1'b1;
            end
            if (mem_ack_in)
            begin
               s_d.mem_req = 1'b0;
               ptr_inc[2*s_q.job_q] = 1'b1;
               // head catching the tail means the free list overflowed; set wins
               if (s_q.job_q == Q_OUT_FREE &&
                   mqu_next(ptr[2*Q_OUT_FREE], size_b) == ptr[2*Q_OUT_FREE+1])
               begin
                  s_d.ofl_full = 1'b1;
               end
               s_d.st = MQU_IDLE;
            end
         end
         MQU_FETCH:
         begin
            if (take)
            begin
               push = 1'b1;
               push_retry = 1'b1;
            end
            if (mem_ack_in)
            begin
               s_d.mem_req = 1'b0;
               s_d.pf_data[s_q.job_q[1]] = mem_rdata_in;
               s_d.pf_valid[s_q.job_q[1]] = !ptr_load[2*s_q.job_q+1];
               s_d.st = MQU_IDLE;
            end
         end
         MQU_SPACE1:
         begin
            if (mem_ack_in)
            begin
               s_d.mem_req = 1'b0;
               s_d.s1_data = s_q.mem_we ? RST_WORD : mem_rdata_in;
               s_d.st = MQU_S1_DONE;
            end
         end
         MQU_S1_DONE:
         begin
            // hold here while the answer buffer is full
            push = 1'b1;
            push_data = s_q.s1_data;
            if (buf_ready)
            begin
               s_d.st = MQU_IDLE;
            end
         end
         default: s_d.st = MQU_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // buffered so a stalled host loses no answer
   mqu_resp_buf #(
      .WIDTH(33),
      .DEPTH(RESP_DEPTH)
   ) u_resp (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .in_valid_in(push),
      .in_ready_out(buf_ready),
      .in_data_in({push_retry, push_data}),
      .out_valid_out(resp_valid_out),
      .out_ready_in(resp_ready_in),
      .out_data_out({resp_retry_out, resp_data_out})
   );

   // interrupts follow queue state; draining clears them
   assign pci_inta_n_out = !(!q_empty[Q_OUT_POST] && !s_q.op_mask);
   assign local_int_out = !q_empty[Q_IN_POST] && !s_q.ip_mask;
   assign local_fatal_error_out = s_q.ofl_full;

   assign mem_req_out = s_q.mem_req;
   assign mem_we_out = s_q.mem_we;
   assign mem_addr_out = s_q.mem_addr;
   assign mem_wdata_out = s_q.mem_wdata;
   assign lreg_rdata_out = s_q.lreg_rdata;
endmodule
`default_nettype wire

// *** mqu_pkg.sv ***
package mqu_pkg;

   // register offsets
   localparam logic [7:0] OFF_QCFG = 8'h00;
   localparam logic [7:0] OFF_QUEUE_BASE_ADDRESS = 8'h04;
   localparam logic [7:0] OFF_PTR0 = 8'h08;
   localparam logic [7:0] OFF_PTR_STEP = 8'h04;
   localparam logic [7:0] OFF_QSR = 8'h28;
   localparam logic [7:0] OFF_OPIS = 8'h30;
   localparam logic [7:0] OFF_OPIM = 8'h34;
   localparam logic [7:0] OFF_LOCAL_MISC_CONTROL = 8'h38;
   localparam logic [7:0] OFF_CLASS = 8'h3C;
   localparam logic [7:0] OFF_IQP = 8'h40;
   localparam logic [7:0] OFF_OQP = 8'h44;
   localparam logic [7:0] OFF_S1RB = 8'h48;

   // field positions
   localparam int QCFG_EN_BIT = 0;
   localparam int QCFG_SIZE_LSB = 1;
   localparam int QSR_DECODE_BIT = 0;
   localparam int QSR_IPMASK_BIT = 4;
   localparam int QSR_IPIRQ_BIT = 5;
   localparam int QSR_OFULL_BIT = 6;
   localparam int OPIS_IRQ_BIT = 3;
   localparam int OPIM_MASK_BIT = 3;
   localparam int LOCAL_MISC_CONTROL_INIT_BIT = 2;
   localparam int QUEUE_BASE_ADDRESS_LSB = 20;
   localparam int S1RB_LSB = 4;

   // sizes and values
   localparam int PTR_W = 20;
   localparam logic [PTR_W-1:0] ENTRY_BYTES = 20'h00004;
   localparam logic [31:0] EMPTY_WORD = 32'hFFFF_FFFF;
   localparam logic [31:0] REG_WINDOW_TOP = 32'h0000_00FF;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [PTR_W-1:0] RST_PTR = 20'h00000;

   // queue order; pointer index 2*queue, +1 tail
   localparam logic [1:0] Q_IN_FREE = 2'h0;
   localparam logic [1:0] Q_IN_POST = 2'h1;
   localparam logic [1:0] Q_OUT_POST = 2'h2;
   localparam logic [1:0] Q_OUT_FREE = 2'h3;
   localparam int NUM_PTR = 8;

   typedef enum logic [2:0] {MQU_IDLE, MQU_POST_WR, MQU_FETCH, MQU_SPACE1, MQU_S1_DONE}
      mqu_state_t;

   // one-hot size code, lowest bit 4k entries
   function automatic logic [PTR_W-1:0] mqu_size_bytes(input logic [4:0] code);
      mqu_size_bytes = {1'b0, code, 14'h0000};
   endfunction

   // step one entry and wrap at the queue size
   function automatic logic [PTR_W-1:0] mqu_next(input logic [PTR_W-1:0] ptr,
                                                 input logic [PTR_W-1:0] size);
      logic [PTR_W-1:0] nxt;
      nxt = ptr + ENTRY_BYTES;
      mqu_next = (nxt == size) ? RST_PTR : nxt;
   endfunction

   // base bits plus queue start plus pointer offset
   function automatic logic [31:0] mqu_qaddr(input logic [11:0] base,
                                             input logic [1:0] q,
                                             input logic [PTR_W-1:0] size,
                                             input logic [PTR_W-1:0] ptr);
      logic [PTR_W-1:0] start;
      start = RST_PTR;
      case (q)
         2'h1: start = size;
         2'h2: start = {size[PTR_W-2:0], 1'b0};
         2'h3: start = {size[PTR_W-2:0], 1'b0} + size;
         default: start = RST_PTR;
      endcase
      mqu_qaddr = {base, 20'h00000} + {12'h000, start} + {12'h000, ptr};
   endfunction

endpackage

// *** mqu_ptr.sv ***
`timescale 1ns/1ps
`default_nettype none
module mqu_ptr
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic load_in,
   input wire logic [mqu_pkg::PTR_W-1:0] load_val_in,
   input wire logic inc_in,
   input wire logic [mqu_pkg::PTR_W-1:0] size_in,
   output logic [mqu_pkg::PTR_W-1:0] ptr_out
);
   import mqu_pkg::*;

   typedef struct packed {
      logic [PTR_W-1:0] ptr;
   } mqu_ptr_state_t;

   mqu_ptr_state_t s_q;
   mqu_ptr_state_t s_d;

   // software load wins; used at setup and whenever the io processor moves a pointer
   always_comb
   begin
      s_d = s_q;
      if (load_in)
      begin
         s_d.ptr = load_val_in;
      end
      else if (inc_in)
      begin
         s_d.ptr = mqu_next(s_q.ptr, size_in);
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign ptr_out = s_q.ptr;
endmodule
`default_nettype wire

// *** mqu_resp_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module mqu_resp_buf
#(
   parameter int WIDTH = 33,
   parameter int DEPTH = 2
)
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_chk
      $error("mqu_resp_buf depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } mqu_buf_state_t;

   mqu_buf_state_t s_q;
   mqu_buf_state_t s_d;
   logic push;
   logic pop;

   // flags from the count; a stalled reader fills it
   assign in_ready_out = (s_q.cnt != DEPTH[AW:0]);
   assign out_valid_out = (s_q.cnt != '0);
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;
   assign out_data_out = s_q.mem[s_q.rp];

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = in_data_in;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop)
      begin
         s_d.rp = s_q.rp + 1'b1;
      end
      if (push && !pop)
      begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
   import mqu_pkg::*;
   localparam logic [31:0] KEY = 32'hA5A5_0000;
   localparam logic [31:0] OPQ = 32'h0010_8000;
   logic clk_in, arst_n_in, req_valid_in, req_ready_out, req_write_in, resp_valid_out;
   logic resp_ready_in, resp_retry_out, mem_req_out, mem_we_out, mem_ack_in, lreg_wr_in;
   logic pci_inta_n_out, local_int_out, local_fatal_error_out, rt;
   logic [31:0] req_addr_in, req_wdata_in, resp_data_out, mem_addr_out, mem_wdata_out;
   logic [31:0] mem_rdata_in, lreg_wdata_in, lreg_rdata_out, wr_addr, wr_data, r;
   logic [7:0] lreg_addr_in;
   logic [3:0] lat;
   int err_count, comparisons, k;
   mqu_message_queue_unit dut (.clk_in, .arst_n_in, .req_valid_in, .req_ready_out,
      .req_write_in, .req_addr_in, .req_wdata_in, .resp_valid_out, .resp_ready_in,
      .resp_data_out, .resp_retry_out, .mem_req_out, .mem_we_out, .mem_addr_out,
      .mem_wdata_out, .mem_ack_in, .mem_rdata_in, .lreg_wr_in, .lreg_addr_in,
      .lreg_wdata_in, .lreg_rdata_out, .pci_inta_n_out, .local_int_out,
      .local_fatal_error_out);
   mqu_mem_model mem (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(mem_req_out),
      .we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .lat_in(lat),
      .ack_out(mem_ack_in), .rdata_out(mem_rdata_in), .wr_addr_out(wr_addr),
      .wr_data_out(wr_data));
   // 200 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic hang();
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      give_verdict();
   endtask
   // local register port
   task automatic lwr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      lreg_wr_in <= 1'b1;
      lreg_addr_in <= a;
      lreg_wdata_in <= d;
      @(posedge clk_in);
      lreg_wr_in <= 1'b0;
      @(negedge clk_in);
   endtask
   task automatic lrd(input logic [7:0] a);
      @(posedge clk_in);
      lreg_addr_in <= a;
      @(posedge clk_in);
      @(negedge clk_in);
      r = lreg_rdata_out;
   endtask
   // one host access and its answer
   task automatic pci(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      req_valid_in <= 1'b1;
      req_write_in <= w;
      req_addr_in <= a;
      req_wdata_in <= d;
      @(negedge clk_in);
      for (n = 0; n < 50 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
      if (n == 50)
         hang();
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      @(negedge clk_in);
      for (n = 0; n < 50 && resp_valid_out !== 1'b1; n++) @(negedge clk_in);
      if (n == 50)
         hang();
      r = resp_data_out;
      rt = resp_retry_out;
      @(posedge clk_in);
   endtask
   // read, repeating on retry
   task automatic pget(input logic [31:0] a);
      rt = 1'b1;
      for (k = 0; k < 20 && rt !== 1'b0; k++) pci(1'b0, a, RST_WORD);
      if (rt !== 1'b0)
         hang();
   endtask
   task automatic idle();
      for (k = 0; k < 50 && mem_req_out !== 1'b0; k++) @(negedge clk_in);
      if (k == 50)
         hang();
   endtask
   task automatic t_reset();
      `CHK(resp_valid_out, 1'b0)
      `CHK(pci_inta_n_out, 1'b1)
      `CHK(local_fatal_error_out, 1'b0)
   endtask
   task automatic t_init();
      pci(1'b0, 32'h44, RST_WORD);
      `CHK(rt, 1'b1)
      lwr(OFF_PTR0 + 8'h1C, 32'h0000_0004);
      lwr(OFF_QUEUE_BASE_ADDRESS, 32'h0010_0000);
      lwr(OFF_S1RB, 32'h0200_0000);
      lwr(OFF_QCFG, 32'h0000_0003);
      lwr(OFF_CLASS, 32'h000E_0100);
      lwr(OFF_QSR, 32'h0000_0001);
      lwr(OFF_LOCAL_MISC_CONTROL, 32'h0000_0004);
      pget(32'h44);
      `CHK(r, EMPTY_WORD)
   endtask
   task automatic t_post();
      lwr(OFF_PTR0 + 8'h10, 32'h0000_0008);
      lrd(OFF_OPIS);
      `CHK(r[OPIS_IRQ_BIT], 1'b1)
      `CHK(pci_inta_n_out, 1'b0)
      pget(32'h44);
      `CHK(r, OPQ ^ KEY)
      pget(32'h44);
      `CHK(r, (OPQ + 32'h4) ^ KEY)
      `CHK(pci_inta_n_out, 1'b1)
      lrd(OFF_OPIS);
      `CHK(r[OPIS_IRQ_BIT], 1'b0)
   endtask
   task automatic t_mask();
      lwr(OFF_OPIM, 32'h0000_0008);
      lat <= 4'h6;
      lwr(OFF_PTR0 + 8'h10, 32'h0000_000C);
      `CHK(pci_inta_n_out, 1'b1)
      lwr(OFF_OPIM, 32'h0000_0000);
      `CHK(pci_inta_n_out, 1'b0)
      pget(32'h44);
      `CHK(r, (OPQ + 32'h8) ^ KEY)
   endtask
   task automatic t_free();
      pci(1'b1, 32'h44, 32'h0BAD_F000);
      `CHK(rt, 1'b0)
      pci(1'b0, 32'h44, RST_WORD);
      `CHK(rt, 1'b1)
      idle();
      lrd(OFF_QSR);
      `CHK(wr_addr, OPQ + 32'h4000)
      `CHK(wr_data, 32'h0BAD_F000)
      `CHK(r[QSR_OFULL_BIT], 1'b1)
      `CHK(local_fatal_error_out, 1'b1)
      lwr(OFF_PTR0 + 8'h1C, 32'h0000_0008);
   endtask
   task automatic t_inbound();
      lat <= 4'h0;
      pci(1'b1, 32'h40, 32'h0000_0200);
      idle();
      lrd(OFF_QSR);
      `CHK(wr_addr, 32'h0010_4000)
      `CHK(local_int_out, 1'b1)
      `CHK(pci_inta_n_out, 1'b1)
      lwr(OFF_PTR0, 32'h0000_0004);
      pget(32'h40);
      `CHK(r, 32'h0010_0000 ^ KEY)
      pget(32'h40);
      `CHK(r, EMPTY_WORD)
   endtask
   task automatic t_space1();
      pget(32'h0000_0104);
      `CHK(r, 32'h0200_0104 ^ KEY)
      pget(32'h0000_0030);
      `CHK(r, RST_WORD)
   endtask
   // main sequence
   initial
   begin
      err_count = 0;
      comparisons = 0;
      arst_n_in = 1'b0;
      req_valid_in = 1'b0;
      req_write_in = 1'b0;
      req_addr_in = RST_WORD;
      req_wdata_in = RST_WORD;
      resp_ready_in = 1'b1;
      lreg_wr_in = 1'b0;
      lreg_addr_in = 8'h00;
      lreg_wdata_in = RST_WORD;
      lat = 4'h1;
      repeat (10) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_reset();
      t_init();
      t_post();
      t_mask();
      t_free();
      t_inbound();
      t_space1();
      give_verdict();
   end
endmodule
bind mqu_message_queue_unit mqu_checker chk (.clk_in, .arst_n_in, .req_valid_in,
   .req_ready_out, .req_write_in, .req_addr_in, .req_wdata_in, .resp_valid_out,
   .resp_retry_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in,
   .lreg_wr_in, .pci_inta_n_out, .local_int_out, .local_fatal_error_out);
`default_nettype wire
